// ### rtl/bss_switch_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module bss_switch_ctrl #(
  parameter int SHIP_MS = bss_pkg::SHIP_DELAY_MS,
  parameter int EXIT_MS = bss_pkg::EXIT_DEGLITCH_MS,
  parameter int HOLD_MS = bss_pkg::RESET_HOLD_MS,
  parameter int OFF_MS = bss_pkg::POWER_OFF_MS,
  parameter int BLINK_MS = bss_pkg::BLINK_HALF_MS,
  parameter int TICK_DIV = bss_pkg::TICK_DIV,
  parameter int IRQ_CYC = bss_pkg::IRQ_PULSE_CYC
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic battery_switch_disable,
  input wire logic ship_entry_delay_sel,
  input wire logic power_cycle_enable,
  input wire logic register_reset,
  input wire logic [1:0] charge_indicator_cfg,
  input wire logic wake_button_n,
  input wire bss_pkg::bss_input_s input_status,
  input wire bss_pkg::bss_charge_s charge_status,
  input wire logic source_identified,
  input wire logic limit_loop_active,
  input wire logic limit_irq_mask,
  input wire logic [7:0] fault_live,
  input wire logic thermistor_fault_live,
  input wire logic fault_read,
  output logic battery_switch_on,
  output logic disable_clear_req,
  output logic input_good_flag,
  output logic input_good_n,
  output logic charge_ind_o,
  output logic charge_ind_oe,
  output logic [7:0] fault_register,
  output logic host_irq_n
);
  // ========================================
  // Reset release and enables
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic tick;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  bss_ms_tick #(.DIV(TICK_DIV)) u_tick (
    .clock(clock),
    .rst_n(rst_n),
    .tick(tick)
  );

  // ========================================
  // Wake button timing
  logic [1:0] btn_sync_q;
  logic btn_low;
  logic [bss_pkg::MS_W-1:0] low_ms_q;
  logic [bss_pkg::MS_W-1:0] low_ms_d;
  logic exit_done_q;
  logic exit_done_d;
  logic cyc_done_q;
  logic cyc_done_d;
  logic exit_hit;
  logic hold_hit;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      btn_sync_q <= 2'b11;
    else
      btn_sync_q <= {btn_sync_q[0], wake_button_n}; // R24
  end
  assign btn_low = !btn_sync_q[1];

  // Counter saturates; any high level restarts both measurements
  always_comb
  begin
    low_ms_d = low_ms_q;
    exit_done_d = exit_done_q;
    cyc_done_d = cyc_done_q;
    if (!btn_low)
    begin
      low_ms_d = '0; // R24
      exit_done_d = 1'b0;
      cyc_done_d = 1'b0;
    end
    else if (tick && low_ms_q != '1)
      low_ms_d = low_ms_q + 1'b1;
    if (exit_hit)
      exit_done_d = 1'b1;
    if (hold_hit)
      cyc_done_d = 1'b1;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_ms_q <= '0;
      exit_done_q <= 1'b0;
      cyc_done_q <= 1'b0;
    end
    else
    begin
      low_ms_q <= low_ms_d;
      exit_done_q <= exit_done_d;
      cyc_done_q <= cyc_done_d;
    end
  end

  // Both fire once per press, so a held button acts only once
  assign exit_hit = btn_low && !exit_done_q && low_ms_q >= bss_pkg::MS_W'(EXIT_MS); // R4
  assign hold_hit = btn_low && !cyc_done_q && low_ms_q >= bss_pkg::MS_W'(HOLD_MS); // R7

  // ========================================
  // Battery switch state machine
  logic in_good;
  logic good_q;
  bss_pkg::bss_sw_e sw_q;
  bss_pkg::bss_sw_e sw_d;
  logic [bss_pkg::MS_W-1:0] sw_ms_q;
  logic [bss_pkg::MS_W-1:0] sw_ms_d;
  logic clr_req_d;
  logic clr_req_q;

  assign in_good = input_status.in_range && input_status.above_battery
    && input_status.load_test_ok && input_status.detect_done; // R11

  always_comb
  begin
    sw_d = sw_q;
    sw_ms_d = sw_ms_q;
    clr_req_d = 1'b0;
    case (sw_q)
      bss_pkg::SW_ON:
      begin
        sw_ms_d = '0;
        if (battery_switch_disable && !register_reset) // R1
          sw_d = ship_entry_delay_sel ? bss_pkg::SW_SHIP_WAIT : bss_pkg::SW_SHIP; // R2
        else if (hold_hit && power_cycle_enable && !input_status.in_range) // R7 R8
          sw_d = bss_pkg::SW_CYCLE_OFF;
      end
      bss_pkg::SW_SHIP_WAIT:
      begin
        if (!battery_switch_disable || register_reset)
          sw_d = bss_pkg::SW_ON;
        else if (tick)
        begin
          sw_ms_d = sw_ms_q + 1'b1;
          if (sw_ms_q == bss_pkg::MS_W'(SHIP_MS - 1))
            sw_d = bss_pkg::SW_SHIP; // R2
        end
      end
      bss_pkg::SW_SHIP:
      begin
        // Input and button exits ask the register side to clear the disable bit
        if (!battery_switch_disable || register_reset) // R5 R6 R9
          sw_d = bss_pkg::SW_ON;
        // Only a fresh arrival of input wakes; input present at entry would bounce back
        else if ((in_good && !good_q) || exit_hit) // R3 R4
        begin
          sw_d = bss_pkg::SW_ON;
          clr_req_d = 1'b1;
        end
      end
      bss_pkg::SW_CYCLE_OFF:
      begin
        if (tick)
        begin
          sw_ms_d = sw_ms_q + 1'b1;
          if (sw_ms_q == bss_pkg::MS_W'(OFF_MS - 1))
            sw_d = bss_pkg::SW_ON; // R7
        end
      end
      default: sw_d = bss_pkg::SW_ON;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sw_q <= bss_pkg::SW_ON;
      sw_ms_q <= '0;
      clr_req_q <= 1'b0;
    end
    else
    begin
      sw_q <= sw_d;
      sw_ms_q <= sw_ms_d;
      clr_req_q <= clr_req_d;
    end
  end

  assign battery_switch_on = (sw_q == bss_pkg::SW_ON) || (sw_q == bss_pkg::SW_SHIP_WAIT);
  assign disable_clear_req = clr_req_q;

  a_cycle_gated: assert property (@(posedge clock) disable iff (!rst_n)
    (sw_q == bss_pkg::SW_ON && $past(sw_q) != bss_pkg::SW_CYCLE_OFF
     && sw_d == bss_pkg::SW_CYCLE_OFF) |-> power_cycle_enable) // R8
    else $error("power cycle without enable");
  a_ship_now: assert property (@(posedge clock) disable iff (!rst_n)
    (sw_q == bss_pkg::SW_ON && battery_switch_disable && !register_reset
     && !ship_entry_delay_sel) |=> !battery_switch_on) // R1
    else $error("switch not opened at once");

  // ========================================
  // Input good and charge indicator
  logic [bss_pkg::MS_W-1:0] blink_ms_q;
  logic [bss_pkg::MS_W-1:0] blink_ms_d;
  logic blink_q;
  logic blink_d;
  logic suspended;

  assign suspended = charge_status.chg_suspend_fault || charge_status.boost_suspend_fault;

  always_comb
  begin
    blink_ms_d = blink_ms_q;
    blink_d = blink_q;
    if (!suspended)
    begin
      blink_ms_d = '0;
      blink_d = 1'b0;
    end
    else if (tick)
    begin
      if (blink_ms_q == bss_pkg::MS_W'(BLINK_MS - 1))
      begin
        blink_ms_d = '0;
        blink_d = !blink_q; // R13 R25
      end
      else
        blink_ms_d = blink_ms_q + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      good_q <= 1'b0;
      blink_ms_q <= '0;
      blink_q <= 1'b0;
    end
    else
    begin
      good_q <= in_good;
      blink_ms_q <= blink_ms_d;
      blink_q <= blink_d;
    end
  end

  assign input_good_flag = good_q; // R10
  assign input_good_n = !good_q; // R10
  // Open drain: drive low only; high means released
  assign charge_ind_o = 1'b0;
  assign charge_ind_oe = (charge_indicator_cfg != bss_pkg::IND_OFF_CFG) // R14
    && (suspended ? blink_q : (charge_status.charging && !charge_status.charge_done)); // R12 R13

  a_ind_off: assert property (@(posedge clock) disable iff (!rst_n)
    (charge_indicator_cfg == bss_pkg::IND_OFF_CFG) |-> !charge_ind_oe) // R14
    else $error("charge pin driven while disabled");

  // ========================================
  // Fault latch and interrupt sources
  logic [7:0] fault_q;
  logic [7:0] fault_d;
  logic fault_armed_q;
  logic fault_armed_d;
  logic good_prev_q;
  logic done_prev_q;
  logic loop_prev_q;
  logic fault_evt;
  logic fire;

  // Fault bit 0 carries the live thermistor condition
  assign fault_evt = |(fault_live & ~fault_q) || (thermistor_fault_live && !fault_q[0]);

  always_comb
  begin
    fault_d = fault_q | fault_live; // R18
    fault_armed_d = fault_armed_q;
    if (fault_read)
    begin
      fault_d = fault_live; // R20
      if (fault_q == bss_pkg::FAULT_RESET)
        fault_armed_d = 1'b1; // R19
    end
    if (fault_evt && fault_armed_q)
      fault_armed_d = 1'b0; // R19
    if (register_reset)
    begin
      fault_d = fault_live;
      fault_armed_d = 1'b1;
    end
    fault_d[0] = thermistor_fault_live; // R21
  end
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fault_q <= bss_pkg::FAULT_RESET;
      fault_armed_q <= 1'b1;
      good_prev_q <= 1'b0;
      done_prev_q <= 1'b0;
      loop_prev_q <= 1'b0;
    end
    else
    begin
      fault_q <= fault_d;
      fault_armed_q <= fault_armed_d;
      good_prev_q <= good_q;
      done_prev_q <= charge_status.charge_done;
      loop_prev_q <= limit_loop_active;
    end
  end

  // Read returns the history, one single-register access at a time
  assign fault_register = fault_q; // R20 R22 R23
  assign fire = (fault_evt && fault_armed_q) // R18 R19
    || (charge_status.charge_done && !done_prev_q) // R16
    || source_identified // R16
    || (good_q != good_prev_q) // R16
    || (limit_loop_active && !loop_prev_q && !limit_irq_mask); // R17

  bss_irq_pulse #(.WIDTH(IRQ_CYC)) u_irq (
    .clock(clock),
    .rst_n(rst_n),
    .fire(fire),
    .irq_n(host_irq_n)
  );

  a_fault_hold: assert property (@(posedge clock) disable iff (!rst_n)
    (!fault_read && !register_reset && fault_q[7]) |=> fault_q[7]) // R18
    else $error("latched fault lost before read");
  a_irq_follow: assert property (@(posedge clock) disable iff (!rst_n)
    (fire && host_irq_n) |=> !host_irq_n) // R15
    else $error("interrupt pulse not started");
  a_good_pin: assert property (@(posedge clock) disable iff (!rst_n)
    input_good_flag != input_good_n) // R10
    else $error("good flag and pin disagree");
endmodule // bss_switch_ctrl
`default_nettype wire

// ### rtl/bss_pkg.sv
// How it works
// R1 - Host setting battery_switch_disable forces the battery switch off (ship mode).
// R2 - Ship entry is immediate, or delayed 8 s when ship_entry_delay_sel is set.
// R3 - In ship mode without input, valid input voltage re-enables the switch.
// R4 - Wake button low for 1 s after a fall exits ship mode.
// R5 - With input present, clearing battery_switch_disable re-enables the switch.
// R6 - register_reset returns all control bits to defaults, clearing the disable bit.
// R7 - No input, disable clear, cycle enabled, button low 16 s: switch off 250 ms.
// R8 - With power_cycle_enable clear, long button presses never power cycle.
// R9 - Without input, toggling the disable bit opens then closes the switch.
// R10 - Good input after detection sets input_good_flag and drives input_good_n low.
// R11 - Input good needs range, above battery, load test and detection done.
// R12 - Charge pin low while charging, released when done, disabled or sleeping.
// R13 - Charge pin blinks at 1 Hz while charging or boost is suspended by faults.
// R14 - Charge indicator configuration 11 disables the charge pin.
// R15 - Each state update sends one 256 us low pulse on host_irq_n. An update during a running pulse sends no pulse of its own.
// R16 - Faults, charge done, source found, input good entry and exit interrupt.
// R17 - Voltage or current limit loop entry interrupts, and only it is maskable.
// R18 - A fault pulses once and latches its bits until the host reads them.
// R19 - No new fault pulse until read and all earlier faults cleared.
// R20 - First read gives history, next read gives only live faults.
// R21 - Thermistor fault field always shows the live condition.
// R22 - Fault register is accessed by single-register transactions only.
// R23 - Host reaches the control bits through an I2C target at address 0x6B.
// R24 - Wake button is synchronised and timed; any high restarts both timers.
// R25 - The 1 Hz blink has roughly equal high and low halves.
package bss_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_HZ = 1000;
  localparam int TICK_DIV = CLK_HZ / TICK_HZ;
  localparam int SHIP_DELAY_MS = 8000;
  localparam int EXIT_DEGLITCH_MS = 1000;
  localparam int RESET_HOLD_MS = 16000;
  localparam int POWER_OFF_MS = 250;
  localparam int BLINK_HALF_MS = 500;
  localparam int IRQ_PULSE_US = 256;
  localparam int IRQ_PULSE_CYC = IRQ_PULSE_US * (CLK_HZ / 1_000_000);
  localparam int MS_W = 15;
  localparam logic [1:0] IND_OFF_CFG = 2'h3;
  localparam logic [7:0] FAULT_RESET = 8'h00;
  localparam logic [6:0] I2C_TARGET_ADDR = 7'h6B;

  typedef struct packed {
    logic in_range;
    logic above_battery;
    logic load_test_ok;
    logic detect_done;
  } bss_input_s;

  typedef struct packed {
    logic charging;
    logic charge_done;
    logic chg_suspend_fault;
    logic boost_suspend_fault;
  } bss_charge_s;

  typedef enum logic [1:0] {
    SW_ON,
    SW_SHIP_WAIT,
    SW_SHIP,
    SW_CYCLE_OFF
  } bss_sw_e;
endpackage

// ### rtl/bss_ms_tick.sv
`timescale 1ns/1ns
`default_nettype none
// ========================================
// Millisecond enable divider
module bss_ms_tick #(
  parameter int DIV = bss_pkg::TICK_DIV
) (
  input wire logic clock,
  input wire logic rst_n,
  output logic tick
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;

  always_comb
  begin
    if (cnt_q == 32'(DIV - 1))
      cnt_d = 32'h0;
    else
      cnt_d = cnt_q + 32'h1;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= 32'h0;
    else
      cnt_q <= cnt_d;
  end

  assign tick = (cnt_q == 32'(DIV - 1));
endmodule // bss_ms_tick
`default_nettype wire

// ### rtl/bss_irq_pulse.sv
`timescale 1ns/1ns
`default_nettype none
// ========================================
// Fixed width low pulse on the host interrupt
module bss_irq_pulse #(
  parameter int WIDTH = bss_pkg::IRQ_PULSE_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic fire,
  output logic irq_n
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;

  // A request during a running pulse merges into it; the host re-reads anyway
  always_comb
  begin
    if (cnt_q != 16'h0)
      cnt_d = cnt_q - 16'h1;
    else if (fire)
      cnt_d = 16'(WIDTH);
    else
      cnt_d = cnt_q;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= 16'h0;
    else
      cnt_q <= cnt_d;
  end

  assign irq_n = (cnt_q == 16'h0); // R15

  a_pulse_width: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(irq_n) |-> !irq_n [*8]) // R15
    else $error("interrupt pulse too short");
endmodule // bss_irq_pulse
`default_nettype wire

// ### verification/bss_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ========================================
// Host control bit and push button stand-in
module bss_host_model (
  input wire logic clock,
  input wire logic set_cmd,
  input wire logic clr_cmd,
  input wire logic register_reset,
  input wire logic disable_clear_req,
  input wire logic [15:0] press_len,
  input wire logic press_go,
  output logic battery_switch_disable,
  output logic wake_button_n
);
  int left = 0;
  initial
    battery_switch_disable = 1'b0;
  // Host bit behaves like a register the device may clear on exit
  always @(posedge clock)
  begin
    if (register_reset || disable_clear_req)
      battery_switch_disable <= 1'b0;
    else if (set_cmd)
      battery_switch_disable <= 1'b1;
    else if (clr_cmd)
      battery_switch_disable <= 1'b0;
    if (press_go)
      left <= press_len;
    else if (left > 0)
      left <= left - 1;
  end
  // Pull-up returns the pin high once the press is over
  assign wake_button_n = (left == 0);
endmodule // bss_host_model
`default_nettype wire

// ### verification/bss_switch_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module bss_switch_ctrl_tb;
  logic clock = 0, reset_n = 0, ship_entry_delay_sel = 0, power_cycle_enable = 0;
  logic register_reset = 0, source_identified = 0, limit_loop_active = 0;
  logic limit_irq_mask = 0, thermistor_fault_live = 0, fault_read = 0;
  logic set_cmd = 0, clr_cmd = 0, press_go = 0, prev;
  logic [1:0] charge_indicator_cfg = 0;
  logic [7:0] fault_live = 0;
  logic [15:0] press_len = 0;
  bss_pkg::bss_input_s input_status = '0;
  bss_pkg::bss_charge_s charge_status = '0;
  wire logic bsd, wake;
  logic battery_switch_on, disable_clear_req, input_good_flag, input_good_n;
  logic charge_ind_o, charge_ind_oe, host_irq_n;
  logic [7:0] fault_register;
  int fail_count = 0, samples_checked = 0;
  always #5 clock = ~clock;
  bss_switch_ctrl #(.SHIP_MS(8), .HOLD_MS(16), .BLINK_MS(5),
    .TICK_DIV(10), .IRQ_CYC(16)) DUT (.clock(clock), .reset_n(reset_n),
    .battery_switch_disable(bsd), .ship_entry_delay_sel(ship_entry_delay_sel),
    .power_cycle_enable(power_cycle_enable), .register_reset(register_reset),
    .charge_indicator_cfg(charge_indicator_cfg), .wake_button_n(wake),
    .input_status(input_status), .charge_status(charge_status),
    .source_identified(source_identified), .limit_loop_active(limit_loop_active),
    .limit_irq_mask(limit_irq_mask), .fault_live(fault_live),
    .thermistor_fault_live(thermistor_fault_live), .fault_read(fault_read),
    .battery_switch_on(battery_switch_on), .disable_clear_req(disable_clear_req),
    .input_good_flag(input_good_flag), .input_good_n(input_good_n),
    .charge_ind_o(charge_ind_o), .charge_ind_oe(charge_ind_oe),
    .fault_register(fault_register), .host_irq_n(host_irq_n));
  bss_host_model host (.clock(clock), .set_cmd(set_cmd), .clr_cmd(clr_cmd),
    .register_reset(register_reset), .disable_clear_req(disable_clear_req),
    .press_len(press_len), .press_go(press_go), .battery_switch_disable(bsd),
    .wake_button_n(wake));
  // ========================================
  // Shared tasks
  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic ship;
    set_cmd = 1'b1;
    cyc(1);
    set_cmd = 1'b0;
    cyc(2);
  endtask
  task automatic press(input int len);
    press_len = 16'(len);
    press_go = 1'b1;
    cyc(1);
    press_go = 1'b0;
  endtask
  task automatic rd_fault;
    fault_read = 1'b1;
    cyc(1);
    fault_read = 1'b0;
    cyc(2);
  endtask
  // Bounded wait on the switch; running out ends the run
  task automatic wait_sw(input logic v, input int lim, output int n);
    n = 0;
    while (battery_switch_on !== v && n < lim)
    begin
      n++;
      cyc(1);
    end
    if (battery_switch_on !== v)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, battery_switch_on, v);
      test_done();
    end
  endtask
  // Pulse must start within a few cycles and last exactly the shortened width
  task automatic irq_seen(input logic exp);
    int w;
    int lowc;
    w = 0;
    lowc = 0;
    while (host_irq_n !== 1'b0 && w < 6)
    begin
      w++;
      cyc(1);
    end
    while (host_irq_n === 1'b0 && lowc < 40)
    begin
      lowc++;
      cyc(1);
    end
    `CHK(lowc != 0, exp)
    if (exp)
      `CHK(lowc, 16)
    cyc(2);
  endtask
  initial
  begin
    #400000;
    fail_count++;
    test_done();
  end
  // ========================================
  // Main sequence
  initial
  begin
    int n;
    int b;
    int c;
    int hi;
    int tg;
    n = $urandom(32'hBE81);
    cyc(8);
    reset_n = 1'b1;
    cyc(5);
    `CHK(battery_switch_on, 1'b1)
    `CHK(host_irq_n, 1'b1)
    for (b = 1; b >= 0; b--)
    begin
      input_status = b ? 4'hF : 4'h0;
      cyc(30);
      ship();
      `CHK(battery_switch_on, 1'b0)
      clr_cmd = 1'b1;
      cyc(1);
      clr_cmd = 1'b0;
      cyc(2);
      `CHK(battery_switch_on, 1'b1)
    end
    ship_entry_delay_sel = 1'b1;
    ship();
    cyc(47);
    `CHK(battery_switch_on, 1'b1)
    wait_sw(1'b0, 100, n);
    `CHK((n + 50) inside {[68:95]}, 1'b1)
    ship_entry_delay_sel = 1'b0;
    input_status = 4'hF;
    wait_sw(1'b1, 20, n);
    cyc(3);
    `CHK(bsd, 1'b0)
    input_status = 4'h0;
    ship();
    press(25);
    cyc(45);
    `CHK(battery_switch_on, 1'b0)
    press(10030);
    wait_sw(1'b1, 10200, n);
    `CHK(n >= 9990, 1'b1)
    cyc(60);
    power_cycle_enable = 1'b1;
    press(175);
    wait_sw(1'b0, 200, n);
    `CHK(n >= 150, 1'b1)
    wait_sw(1'b1, 2600, n);
    `CHK(n inside {[2480:2520]}, 1'b1)
    cyc(30);
    power_cycle_enable = 1'b0;
    press(250);
    n = 0;
    repeat (260)
    begin
      cyc(1);
      n += (battery_switch_on !== 1'b1);
    end
    `CHK(n, 0)
    ship();
    register_reset = 1'b1;
    cyc(1);
    register_reset = 1'b0;
    wait_sw(1'b1, 5, n);
    `CHK(battery_switch_on, 1'b1)
    // ========================================
    // Input good, interrupt sources
    for (b = 0; b < 16; b++)
    begin
      input_status = 4'(b);
      cyc(3);
      `CHK(input_good_flag, logic'(b == 15))
      `CHK(input_good_n, logic'(b != 15))
    end
    cyc(30);
    input_status = 4'h7;
    irq_seen(1'b1);
    input_status = 4'hF;
    irq_seen(1'b1);
    source_identified = 1'b1;
    cyc(1);
    source_identified = 1'b0;
    irq_seen(1'b1);
    charge_status = 4'h4;
    irq_seen(1'b1);
    limit_irq_mask = 1'b1;
    limit_loop_active = 1'b1;
    irq_seen(1'b0);
    limit_loop_active = 1'b0;
    limit_irq_mask = 1'b0;
    cyc(2);
    limit_loop_active = 1'b1;
    irq_seen(1'b1);
    limit_loop_active = 1'b0;
    // ========================================
    // Charge indicator pin
    charge_status = 4'h8;
    cyc(3);
    `CHK({charge_ind_oe, charge_ind_o}, 2'h2)
    charge_indicator_cfg = 2'h3;
    cyc(3);
    `CHK(charge_ind_oe, 1'b0)
    charge_indicator_cfg = 2'h0;
    charge_status = 4'h4;
    cyc(3);
    `CHK(charge_ind_oe, 1'b0)
    for (b = 0; b < 2; b++)
    begin
      charge_status = b ? 4'h1 : 4'h2;
      hi = 0;
      tg = 0;
      cyc(1);
      repeat (200)
      begin
        prev = charge_ind_oe;
        cyc(1);
        hi += int'(charge_ind_oe === 1'b1);
        tg += int'(charge_ind_oe !== prev);
      end
      `CHK(hi inside {[80:120]}, 1'b1)
      `CHK(tg >= 3, 1'b1)
    end
    charge_status = 4'h0;
    cyc(40);
    // ========================================
    // Fault latch and interrupt rearm
    b = $urandom_range(7, 1);
    c = (b % 7) + 1;
    fault_live = 8'h01 << b;
    irq_seen(1'b1);
    fault_live = 8'h00;
    cyc(2);
    `CHK(fault_register[b], 1'b1)
    fault_live = 8'h01 << c;
    irq_seen(1'b0);
    fault_live = 8'h00;
    rd_fault();
    `CHK(fault_register & 8'hFE, 8'h00)
    rd_fault();
    fault_live = 8'h01 << b;
    irq_seen(1'b1);
    fault_live = 8'h00;
    rd_fault();
    rd_fault();
    thermistor_fault_live = 1'b1;
    cyc(2);
    `CHK(fault_register[0], 1'b1)
    thermistor_fault_live = 1'b0;
    cyc(2);
    `CHK(fault_register[0], 1'b0)
    test_done();
  end
endmodule // bss_switch_ctrl_tb
`default_nettype wire
